// >>> design/rdpg_regs.sv
// Contract
// - Sleep-select 00 keeps the normal voltage, 11 takes sleep voltage while the sleep pin is low.
// - The governing sleep pin is fixed at build time, not by register.
// - Run bit 0 low forces regulator three off regardless of control pins.
// - A discharge field clears to 00 while its rail is enabled.
// - Discharge codes select none, 100, 200 or 500 ohm paths.
// - First discharge register holds switchers four to one, high to low.
// - Second holds regulator two, load switch A1, switchers six and five.
// - Third holds B2, B1 and regulator three; top two bits read zero.
// - Delay register holds a 3-bit code; upper five bits read zero.
// - Delay runs once all grouped rails regulate, then power good asserts.
// - Codes select 2.5, 5, 10, 15, 20, 50 and 100 ms delays.
// - The delay has no effect when output three is under bus control.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rdpg_regs
   import rdpg_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES,
   parameter bit SLEEP_PIN_TWO = 1'b0
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // APB slave
   input wire rdpg_apb_req_t apbReq,
   output var rdpg_apb_rsp_t apbRsp,
   // Rail status pins
   input wire logic [N_RAILS-1:0] voltageRailEnabled,
   input wire logic groupRailsGood,
   // Regulator three pins
   input wire logic sleepPinOne,
   input wire logic sleepPinTwo,
   input wire logic controlInputsEnable,
   // Output three configuration
   input wire logic outputThreeBusMode,
   input wire logic outputThreeVttUse,
   input wire logic outputThreeBusLevel,
   // Analog controls
   output logic ldoThreeEnable,
   output logic ldoThreeUseSleep,
   output logic [3*N_RAILS-1:0] dischargePath,
   output logic generalOutputThree
);

   rdpg_main_st_t st_r;
   rdpg_main_st_t st_nxt;
   logic [2*N_RAILS-1:0] clrMask;
   logic [3*N_RAILS-1:0] dischDec;
   logic pgDone;
   logic [N_SYNC-1:0] pinVec;
   logic [IDX_W-1:0] idx;
   logic setupPh;
   logic accessPh;
   logic mapped;

   // ----------------------------------------------------------------
   // Per-rail clear and decode
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N_RAILS; g++)
   begin : g_rail
      logic [1:0] fld;
      assign fld = st_r.disch[2*g +: 2];
      assign clrMask[2*g +: 2] = {2{st_r.syncB[SY_RAIL + g]}};
      assign dischDec[3*g +: 3] = (fld == DCODE_100) ? DPATH_100 :
                                  (fld == DCODE_200) ? DPATH_200 :
                                  (fld == DCODE_500) ? DPATH_500 :
                                  DPATH_NONE;
   end

   // ----------------------------------------------------------------
   // Power good delay
   // ----------------------------------------------------------------
   rdpg_pg_timer #(
      .TICKS(TICKS)
   ) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .railsGood(st_r.syncB[SY_GOOD]),
      .code(st_r.pgCode),
      .done(pgDone)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign pinVec = {outputThreeBusLevel, outputThreeVttUse,
                    outputThreeBusMode, groupRailsGood,
                    controlInputsEnable, sleepPinTwo, sleepPinOne,
                    voltageRailEnabled};
   assign idx = apbReq.paddr[ADDR_W-1:2];
   assign setupPh = apbReq.psel && !apbReq.penable;
   assign accessPh = apbReq.psel && apbReq.penable && st_r.rsp.pready;
   assign mapped = (idx inside {IDX_LDO3, IDX_DISCH1, IDX_DISCH2,
                   IDX_DISCH3, IDX_PGDLY}) && apbReq.paddr[1:0] == 2'h0;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] rd;
      logic hit;
      logic slpPin;
      rd = 8'h00;
      hit = 1'b1;
      slpPin = 1'b0;
      st_nxt = st_r;
      st_nxt.syncA = pinVec;
      st_nxt.syncB = st_r.syncA;

      // Read data captured in setup, answered next cycle
      case (idx)
         IDX_LDO3: rd = {2'h0, st_r.ldoCtl};
         IDX_DISCH1: rd = st_r.disch[7:0];
         IDX_DISCH2: rd = st_r.disch[15:8];
         IDX_DISCH3: rd = {2'h0, st_r.disch[21:16]};
         IDX_PGDLY: rd = {5'h00, st_r.pgCode};
         default: hit = 1'b0;
      endcase
      if (apbReq.paddr[1:0] != 2'h0)
      begin
         hit = 1'b0;
      end
      st_nxt.rsp.pready = setupPh;
      if (setupPh)
      begin
         st_nxt.rsp.pslverr = !hit;
         st_nxt.rsp.prdata = hit ? {24'h000000, rd} : 32'h00000000;
      end

      // Writes take effect at the access edge
      if (accessPh && apbReq.pwrite && !st_r.rsp.pslverr)
      begin
         case (idx)
            IDX_LDO3: st_nxt.ldoCtl = apbReq.pwdata[5:0];
            IDX_DISCH1: st_nxt.disch[7:0] = apbReq.pwdata[7:0];
            IDX_DISCH2: st_nxt.disch[15:8] = apbReq.pwdata[7:0];
            IDX_DISCH3: st_nxt.disch[21:16] = apbReq.pwdata[5:0];
            IDX_PGDLY: st_nxt.pgCode = apbReq.pwdata[2:0];
            default: st_nxt.pgCode = st_r.pgCode;
         endcase
      end

      // Enabled rails override software
      st_nxt.disch = st_nxt.disch & ~clrMask;

      // Regulator three
      st_nxt.ldoEn = st_r.ldoCtl[LDO_RUN_BIT] &&
                     st_r.syncB[SY_CTL];
      slpPin = SLEEP_PIN_TWO ? st_r.syncB[SY_SLP2] :
               st_r.syncB[SY_SLP1];
      st_nxt.useSleep = (st_r.ldoCtl[LDO_SLP_LSB +: 2] == SLEEP_ON_PIN) &&
                        !slpPin;

      st_nxt.dischPath = dischDec;

      // Output three
      if (st_r.syncB[SY_BUS] && !st_r.syncB[SY_VTT])
      begin
         st_nxt.gpoThree = st_r.syncB[SY_LVL];
      end
      else
      begin
         st_nxt.gpoThree = pgDone;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= MAIN_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign apbRsp = st_r.rsp;
   assign ldoThreeEnable = st_r.ldoEn;
   assign ldoThreeUseSleep = st_r.useSleep;
   assign dischargePath = st_r.dischPath;
   assign generalOutputThree = st_r.gpoThree;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_ldo_forced_off: assert property (
      !st_r.ldoCtl[LDO_RUN_BIT] |=> !ldoThreeEnable)
      else $error("Regulator three on with run bit low");
   a_sleep_normal_sel: assert property (
      st_r.ldoCtl[LDO_SLP_LSB +: 2] == SLEEP_NORMAL |=> !ldoThreeUseSleep)
      else $error("Sleep voltage used with select 00");
   a_sleep_pin_low: assert property (
      st_r.ldoCtl[LDO_SLP_LSB +: 2] == SLEEP_ON_PIN &&
      !(SLEEP_PIN_TWO ? st_r.syncB[SY_SLP2] : st_r.syncB[SY_SLP1])
      |=> ldoThreeUseSleep)
      else $error("Sleep voltage not used with pin low");
   a_disch_rail_clear: assert property (
      st_r.syncB[SY_RAIL + 8] |=> st_r.disch[17:16] == 2'h0)
      else $error("Discharge field kept while rail enabled");
   a_disch_decode: assert property (
      st_r.disch[1:0] == DCODE_500 |=> dischargePath[2:0] == DPATH_500)
      else $error("Discharge code 11 not decoded to 500 ohm");
   a_disch1_write: assert property (
      accessPh && apbReq.pwrite && idx == IDX_DISCH1 &&
      !st_r.rsp.pslverr && st_r.syncB[3:0] == 4'h0
      |=> st_r.disch[7:0] == $past(apbReq.pwdata[7:0]))
      else $error("First discharge register write lost");
   a_disch2_read: assert property (
      setupPh && idx == IDX_DISCH2 && apbReq.paddr[1:0] == 2'h0
      |=> apbRsp.prdata == {24'h000000, $past(st_r.disch[15:8])})
      else $error("Second discharge register read wrong");
   a_disch3_resv: assert property (
      setupPh && idx == IDX_DISCH3 |=> apbRsp.prdata[31:6] == 26'h0)
      else $error("Third discharge reserved bits not zero");
   a_pgdly_resv: assert property (
      setupPh && idx == IDX_PGDLY |=> apbRsp.prdata[31:3] == 29'h0)
      else $error("Delay register reserved bits not zero");
   a_bus_mode_out: assert property (
      st_r.syncB[SY_BUS] && !st_r.syncB[SY_VTT]
      |=> generalOutputThree == $past(st_r.syncB[SY_LVL]))
      else $error("Output three not under bus control");
   a_apb_one_wait: assert property (setupPh |=> apbRsp.pready ##1
      !apbRsp.pready)
      else $error("Access phase not exactly one cycle");

   a_disch2_write: assert property (
      accessPh && apbReq.pwrite && idx == IDX_DISCH2 &&
      !st_r.rsp.pslverr && st_r.syncB[7:4] == 4'h0
      |=> st_r.disch[15:8] == $past(apbReq.pwdata[7:0]))
      else $error("Second discharge register write lost");
   a_disch3_write: assert property (
      accessPh && apbReq.pwrite && idx == IDX_DISCH3 &&
      !st_r.rsp.pslverr && st_r.syncB[10:8] == 3'h0
      |=> st_r.disch[21:16] == $past(apbReq.pwdata[5:0]))
      else $error("Third discharge register write lost");
   a_pgdly_write: assert property (
      accessPh && apbReq.pwrite && idx == IDX_PGDLY && !st_r.rsp.pslverr
      |=> st_r.pgCode == $past(apbReq.pwdata[2:0]))
      else $error("Delay code write lost");
   a_ldo_write: assert property (
      accessPh && apbReq.pwrite && idx == IDX_LDO3 && !st_r.rsp.pslverr
      |=> st_r.ldoCtl == $past(apbReq.pwdata[5:0]))
      else $error("Regulator three control write lost");
   a_disch1_read: assert property (
      setupPh && idx == IDX_DISCH1 && apbReq.paddr[1:0] == 2'h0
      |=> apbRsp.prdata == {24'h000000, $past(st_r.disch[7:0])})
      else $error("First discharge register read wrong");
   a_disch3_read: assert property (
      setupPh && idx == IDX_DISCH3 && apbReq.paddr[1:0] == 2'h0
      |=> apbRsp.prdata[5:0] == $past(st_r.disch[21:16]))
      else $error("Third discharge register read wrong");
   a_pgdly_read: assert property (
      setupPh && idx == IDX_PGDLY && apbReq.paddr[1:0] == 2'h0
      |=> apbRsp.prdata[2:0] == $past(st_r.pgCode))
      else $error("Delay code read wrong");
   a_ldo_read: assert property (
      setupPh && idx == IDX_LDO3 && apbReq.paddr[1:0] == 2'h0
      |=> apbRsp.prdata == {26'h0, $past(st_r.ldoCtl)})
      else $error("Regulator three control read wrong");
   a_ldo_enabled: assert property (
      st_r.ldoCtl[LDO_RUN_BIT] && st_r.syncB[SY_CTL] |=> ldoThreeEnable)
      else $error("Regulator three off with run bit and pins high");
   a_ldo_pin_low: assert property (
      !st_r.syncB[SY_CTL] |=> !ldoThreeEnable)
      else $error("Regulator three on with control pins low");
   a_sleep_pin_high: assert property (
      st_r.ldoCtl[LDO_SLP_LSB +: 2] == SLEEP_ON_PIN &&
      (SLEEP_PIN_TWO ? st_r.syncB[SY_SLP2] : st_r.syncB[SY_SLP1])
      |=> !ldoThreeUseSleep)
      else $error("Sleep voltage used with pin high");
   a_sleep_resv_code: assert property (
      st_r.ldoCtl[LDO_SLP_LSB +: 2] != SLEEP_ON_PIN |=> !ldoThreeUseSleep)
      else $error("Sleep voltage used without select 11");
   a_pg_out: assert property (
      !(st_r.syncB[SY_BUS] && !st_r.syncB[SY_VTT])
      |=> generalOutputThree == $past(pgDone))
      else $error("Output three not following power good");
   a_ready_idle: assert property (
      !setupPh |=> !apbRsp.pready)
      else $error("Ready without a setup cycle");
   a_resp_hold: assert property (
      !setupPh |=> $stable(apbRsp.pslverr) && $stable(apbRsp.prdata))
      else $error("Response changed without a setup cycle");
   a_mapped_no_err: assert property (setupPh && mapped |=> !apbRsp.pslverr)
      else $error("Error flagged on a mapped register");
   a_bad_addr_err: assert property (
      setupPh && !mapped |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
      else $error("Unmapped access not refused");
   a_err_no_write: assert property (
      accessPh && st_r.rsp.pslverr
      |=> st_r.ldoCtl == $past(st_r.ldoCtl) &&
      st_r.pgCode == $past(st_r.pgCode))
      else $error("Refused write changed a register");

   for (genvar r = 0; r < N_RAILS; r++)
   begin : g_rail_chk
      a_rail_clear: assert property (
         st_r.syncB[SY_RAIL + r] |=> st_r.disch[2*r +: 2] == 2'h0)
         else $error("Discharge field kept while rail enabled");
      a_rail_kept: assert property (
         !st_r.syncB[SY_RAIL + r] && !(accessPh && apbReq.pwrite)
         |=> $stable(st_r.disch[2*r +: 2]))
         else $error("Discharge field changed without write");
      a_path_none: assert property (
         st_r.disch[2*r +: 2] == 2'h0
         |=> dischargePath[3*r +: 3] == DPATH_NONE)
         else $error("Discharge code 00 not decoded to none");
      a_path_100: assert property (
         st_r.disch[2*r +: 2] == DCODE_100
         |=> dischargePath[3*r +: 3] == DPATH_100)
         else $error("Discharge code 01 not decoded to 100 ohm");
      a_path_200: assert property (
         st_r.disch[2*r +: 2] == DCODE_200
         |=> dischargePath[3*r +: 3] == DPATH_200)
         else $error("Discharge code 10 not decoded to 200 ohm");
      a_path_500: assert property (
         st_r.disch[2*r +: 2] == DCODE_500
         |=> dischargePath[3*r +: 3] == DPATH_500)
         else $error("Discharge code 11 not decoded to 500 ohm");
   end

   c_sleep_used: cover property ($rose(ldoThreeUseSleep));
   c_disch_cleared: cover property (st_r.disch != '0 ##1 st_r.disch == '0);
   c_out_three_pg: cover property ($rose(generalOutputThree));
   c_write_err: cover property (accessPh && st_r.rsp.pslverr);

endmodule
`default_nettype wire

// >>> design/rdpg_pkg.sv
`default_nettype none
package rdpg_pkg;

   // ----------------------------------------------------------------
   // Bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int IDX_W = ADDR_W - 2;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_LDO3 = 10'h029;
   localparam logic [IDX_W-1:0] IDX_DISCH1 = 10'h040;
   localparam logic [IDX_W-1:0] IDX_DISCH2 = 10'h041;
   localparam logic [IDX_W-1:0] IDX_DISCH3 = 10'h042;
   localparam logic [IDX_W-1:0] IDX_PGDLY = 10'h043;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int LDO_RUN_BIT = 0;
   localparam int LDO_SLP_LSB = 4;
   localparam logic [5:0] LDO_RESET = 6'h0C;
   localparam logic [1:0] SLEEP_NORMAL = 2'h0;
   localparam logic [1:0] SLEEP_ON_PIN = 2'h3;
   localparam int N_RAILS = 11;
   localparam logic [21:0] DISCH_RESET = 22'h000000;
   localparam logic [2:0] PG_RESET = 3'h0;
   localparam logic [1:0] DCODE_100 = 2'h1;
   localparam logic [1:0] DCODE_200 = 2'h2;
   localparam logic [1:0] DCODE_500 = 2'h3;
   localparam logic [2:0] DPATH_NONE = 3'h0;
   localparam logic [2:0] DPATH_100 = 3'h1;
   localparam logic [2:0] DPATH_200 = 3'h2;
   localparam logic [2:0] DPATH_500 = 3'h4;

   // ----------------------------------------------------------------
   // Synchroniser bit positions
   // ----------------------------------------------------------------
   localparam int SY_RAIL = 0;
   localparam int SY_SLP1 = 11;
   localparam int SY_SLP2 = 12;
   localparam int SY_CTL = 13;
   localparam int SY_GOOD = 14;
   localparam int SY_BUS = 15;
   localparam int SY_VTT = 16;
   localparam int SY_LVL = 17;
   localparam int N_SYNC = 18;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int DLY0_US = 2500;
   localparam int DLY1_US = 5000;
   localparam int DLY2_US = 10000;
   localparam int DLY3_US = 15000;
   localparam int DLY4_US = 20000;
   localparam int DLY5_US = 50000;
   localparam int DLY7_US = 100000;
   localparam logic [9:0] DT0 = 10'(DLY0_US / TICK_US);
   localparam logic [9:0] DT1 = 10'(DLY1_US / TICK_US);
   localparam logic [9:0] DT2 = 10'(DLY2_US / TICK_US);
   localparam logic [9:0] DT3 = 10'(DLY3_US / TICK_US);
   localparam logic [9:0] DT4 = 10'(DLY4_US / TICK_US);
   localparam logic [9:0] DT5 = 10'(DLY5_US / TICK_US);
   localparam logic [9:0] DT7 = 10'(DLY7_US / TICK_US);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } rdpg_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rdpg_apb_rsp_t;

   typedef struct packed {
      logic [N_SYNC-1:0] syncA;
      logic [N_SYNC-1:0] syncB;
      logic [5:0] ldoCtl;
      logic [21:0] disch;
      logic [2:0] pgCode;
      rdpg_apb_rsp_t rsp;
      logic ldoEn;
      logic useSleep;
      logic [3*N_RAILS-1:0] dischPath;
      logic gpoThree;
   } rdpg_main_st_t;

   typedef struct packed {
      logic [15:0] pre;
      logic [9:0] ticks;
      logic done;
   } rdpg_tmr_st_t;

   localparam rdpg_main_st_t MAIN_RST = '{
      syncA: '0, syncB: '0, ldoCtl: LDO_RESET, disch: DISCH_RESET,
      pgCode: PG_RESET, rsp: '0, ldoEn: 1'b0, useSleep: 1'b0,
      dischPath: '0, gpoThree: 1'b0};

endpackage
`default_nettype wire

// >>> design/rdpg_pg_timer.sv
`timescale 1ns/1ns
`default_nettype none
module rdpg_pg_timer
   import rdpg_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Control
   input wire logic railsGood,
   input wire logic [2:0] code,
   // Result
   output logic done
);

   rdpg_tmr_st_t st_r;
   rdpg_tmr_st_t st_nxt;
   logic [9:0] target;

   if (TICKS < 1 || TICKS > 65536)
   begin : g_chk
      $error("Tick prescale out of range");
   end

   // ----------------------------------------------------------------
   // Delay select
   // ----------------------------------------------------------------
   always_comb
   begin
      case (code)
         3'h0: target = DT0;
         3'h1: target = DT1;
         3'h2: target = DT2;
         3'h3: target = DT3;
         3'h4: target = DT4;
         3'h5: target = DT5;
         3'h7: target = DT7;
         default: target = DT7;
      endcase
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      if (!railsGood)
      begin
         st_nxt = '0;
      end
      else if (st_r.ticks < target)
      begin
         if (st_r.pre == 16'(TICKS - 1))
         begin
            st_nxt.pre = '0;
            st_nxt.ticks = st_r.ticks + 10'h001;
         end
         else
         begin
            st_nxt.pre = st_r.pre + 16'h0001;
         end
      end
      else
      begin
         st_nxt.done = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign done = st_r.done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_good_drop_clears: assert property (!railsGood |=> !done)
      else $error("Power good held after rails left regulation");
   a_delay_reached: assert property ($rose(done) |->
      $past(st_r.ticks) >= $past(target) && $past(railsGood))
      else $error("Power good before delay expired");
   a_reserved_code: assert property (code == 3'h6 |-> target == DT7)
      else $error("Unlisted delay code not mapped to longest");
   c_pg_asserted: cover property ($rose(done));

endmodule
`default_nettype wire

// >>> dv/rdpg_host.sv
`timescale 1ns/1ns
`default_nettype none
module rdpg_host
   import rdpg_pkg::*;
(
   // Clock
   input wire logic clock,
   // APB master
   output var rdpg_apb_req_t apbReq,
   input wire rdpg_apb_rsp_t apbRsp
);
   // ----------------------------------------------------------------
   // Transfer
   // ----------------------------------------------------------------
   initial
   begin
      apbReq = '0;
   end

   // Entered just after a rising edge; penable low on entry
   task automatic xfer(input logic isWr, input logic [ADDR_W-1:0] addr,
      input logic [31:0] data, input logic last);
      logic [31:0] d;
      d = data;
      if (isWr && addr == {IDX_LDO3, 2'b00})
      begin
         d[3:1] = 3'b110;
         if (d[5] != d[4])
         begin
            d[5:4] = 2'b00;
         end
      end
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= isWr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= d;
      @(posedge clock);
      apbReq.penable <= 1'b1;
      @(posedge clock);
      while (apbRsp.pready !== 1'b1)
      begin
         @(posedge clock);
      end
      apbReq.penable <= 1'b0;
      if (last)
      begin
         apbReq.psel <= 1'b0;
         @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
   import rdpg_pkg::*;
;
   localparam int TK = 4;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   rdpg_apb_req_t apbReq;
   rdpg_apb_rsp_t apbRsp;
   logic [10:0] rails = 11'h000;
   logic good = 1'b0;
   logic slp1 = 1'b1;
   logic slp2 = 1'b1;
   logic ctlEn = 1'b0;
   logic busMode = 1'b0;
   logic vtt = 1'b0;
   logic busLvl = 1'b0;
   logic ldoEn, ldoSlp, gpo;
   logic [32:0] path;
   logic [32:0] obs;
   logic [32:0] expQ[$];
   logic [32:0] mskQ[$];
   logic [21:0] fld = 22'h000000;
   logic eEn = 1'b0;
   logic eSlp = 1'b0;
   logic eG = 1'b0;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int tk[8] = '{25, 50, 100, 150, 200, 500, 1000, 1000};

   always #5 clock = ~clock;

   rdpg_regs #(.TICKS(TK), .SLEEP_PIN_TWO(1'b0)) u_dut (
      .clock(clock), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
      .voltageRailEnabled(rails), .groupRailsGood(good),
      .sleepPinOne(slp1), .sleepPinTwo(slp2),
      .controlInputsEnable(ctlEn), .outputThreeBusMode(busMode),
      .outputThreeVttUse(vtt), .outputThreeBusLevel(busLvl),
      .ldoThreeEnable(ldoEn), .ldoThreeUseSleep(ldoSlp),
      .dischargePath(path), .generalOutputThree(gpo));

   rdpg_host u_host (.clock(clock), .apbReq(apbReq), .apbRsp(apbRsp));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic results;
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [32:0] dpath(input logic [21:0] f);
      logic [32:0] p;
      for (int i = 0; i < 11; i++)
      begin
         p[3*i+:3] = (f[2*i+:2] == 2'h3) ? 3'h4 : {1'b0, f[2*i+:2]};
      end
      return p;
   endfunction

   function automatic logic [21:0] cmask(input logic [10:0] r);
      logic [21:0] m;
      for (int i = 0; i < 11; i++)
      begin
         m[2*i+:2] = {2{r[i]}};
      end
      return m;
   endfunction

   task automatic xf(input logic isWr, input logic [IDX_W-1:0] idx,
      input logic [7:0] d, input logic [32:0] e, input logic last);
      expQ.push_back(e);
      mskQ.push_back(isWr ? 33'h1_0000_0000 : {33{1'b1}});
      u_host.xfer(isWr, {idx, 2'b00}, {24'h0, d}, last);
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
      input logic last);
      xf(1'b1, idx, d, 33'h0, last);
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, input logic [32:0] e);
      xf(1'b0, idx, 8'h00, e, 1'b1);
   endtask

   task automatic wrAll(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] c);
      fld = {c[5:0], b, a} & ~cmask(rails);
      wr(IDX_DISCH1, a, 1'b0);
      wr(IDX_DISCH2, b, 1'b0);
      wr(IDX_DISCH3, c, 1'b0);
   endtask

   task automatic rdAll;
      rd(IDX_DISCH1, 33'(fld[7:0]));
      rd(IDX_DISCH2, 33'(fld[15:8]));
      rd(IDX_DISCH3, 33'(fld[21:16]));
   endtask

   task automatic pins;
      logic [39:0] s;
      repeat (4) @(posedge clock);
      @(negedge clock);
      s = {4'h0, ldoEn, ldoSlp, gpo, path};
      check(s, {4'h0, eEn, eSlp, eG, dpath(fld)});
      @(posedge clock);
   endtask

   // ----------------------------------------------------------------
   // Watchdog and response monitor
   // ----------------------------------------------------------------
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         fails++;
         results();
      end
      else if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1
         && expQ.size() > 0)
      begin
         obs = {apbRsp.pslverr, apbRsp.prdata} & mskQ[0];
         check(40'(obs), 40'(expQ[0]));
         void'(expQ.pop_front());
         void'(mskQ.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [7:0] a, b, c;
      int n;
      void'($urandom(32'hD9096C09));
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rd(IDX_LDO3, 33'h0C);
      rdAll();
      rd(IDX_PGDLY, 33'h0);
      rd(10'h3FF, 33'h1_0000_0000);
      xf(1'b1, 10'h3FE, 8'hFF, 33'h1_0000_0000, 1'b1);
      pins();
      for (int k = 0; k < 7; k++)
      begin
         a = (k < 4) ? {4{2'(k)}} : 8'($urandom);
         b = (k < 4) ? a : 8'($urandom);
         c = (k < 4) ? a : 8'($urandom);
         wrAll(a, b, c);
         wr(IDX_PGDLY, c, 1'b1);
         rdAll();
         rd(IDX_PGDLY, 33'(c[2:0]));
         pins();
      end
      rails <= 11'($urandom) | 11'h001;
      @(posedge clock);
      fld = fld & ~cmask(rails);
      pins();
      wrAll(8'hFF, 8'hFF, 8'hFF);
      wr(IDX_PGDLY, 8'h00, 1'b1);
      rdAll();
      rails <= 11'h000;
      pins();
      ctlEn <= 1'b1;
      wr(IDX_LDO3, 8'h31, 1'b1);
      eEn = 1'b1;
      pins();
      ctlEn <= 1'b0;
      eEn = 1'b0;
      pins();
      ctlEn <= 1'b1;
      slp2 <= 1'b0;
      eEn = 1'b1;
      pins();
      slp1 <= 1'b0;
      eSlp = 1'b1;
      pins();
      rd(IDX_LDO3, 33'h3D);
      wr(IDX_LDO3, 8'h10, 1'b1);
      eEn = 1'b0;
      eSlp = 1'b0;
      pins();
      rd(IDX_LDO3, 33'h0C);
      for (int k = 0; k < 8; k++)
      begin
         wr(IDX_PGDLY, 8'(k), 1'b1);
         good <= 1'b1;
         n = 0;
         while (gpo !== 1'b1 && n < 5000)
         begin
            @(negedge clock);
            n++;
         end
         a = 8'(n * 10 >= tk[k] * TK * 9 && n * 10 <= tk[k] * TK * 11);
         check(40'(a), 40'h1);
         @(posedge clock);
         good <= 1'b0;
         pins();
      end
      wr(IDX_PGDLY, 8'h00, 1'b1);
      busMode <= 1'b1;
      busLvl <= 1'b1;
      eG = 1'b1;
      pins();
      busLvl <= 1'b0;
      good <= 1'b1;
      eG = 1'b0;
      repeat (150) @(posedge clock);
      pins();
      vtt <= 1'b1;
      eG = 1'b1;
      pins();
      results();
   end
endmodule
`default_nettype wire
